/* File: usbo_otg_event_flags.sv */
`timescale 1ns/1ps
// How it works
// - a change on the identity pin sets event bit 7
// - every expiry of the 1 ms timer sets event bit 6
// - line state stable 1 ms and different from last settled sets bit 5
// - pin activity (D+, D-, id or session valid) while suspended sets bit 4
// - VBUS dropping below session end sets bit 3
// - any change on the session end comparator sets bit 2
// - any change on the session valid comparator sets bit 0
// - flags set by hardware only, reset to zero, cleared by writing one
// - event bit 1 and bits 31..8 read zero and ignore writes
// - identity indicator is one with no cable or B cable, zero for A
// - line stable indicator is one after 1 ms of unchanged line state
// - session valid indicator follows VBUS above session valid
// - session end on B device, VBUS valid on A device indicators
module usbo_otg_event_flags
  import usbo_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // cable side
  input wire logic i_id_pin,
  input wire logic i_dp,
  input wire logic i_dm,
  input wire logic i_single_ended_zero_line,
  input wire logic i_j_state_line,
  input wire logic i_sess_vld,
  input wire logic i_sess_end,
  input wire logic i_a_device,
  input wire logic i_suspend,
  // interrupt
  output logic o_irq
);

  typedef struct packed {
    logic primed;
    logic id_q;
    logic dp_q;
    logic dm_q;
    logic sv_q;
    logic se_q;
    logic [FLAG_W-1:0] evt;
    logic [FLAG_W-1:0] live;
    logic [FLAG_W-1:0] irq_st;
    logic [FLAG_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
  } usbo_core_s;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  usbo_core_s st_ff;
  usbo_core_s nxt_st;
  logic [FLAG_W-1:0] ev;
  logic [FLAG_W-1:0] wr_clr;
  logic pin_moved;

  usbo_tmr_if tif ();

  assign tif.single_ended_zero_line = i_single_ended_zero_line;
  assign tif.j_state_line = i_j_state_line;

  usbo_line_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .tif(tif.timer)
  );

  // primed blocks false edges against the reset values of the samples
  always_comb begin
    ev = FLAGS_RST;
    pin_moved = (i_dp != st_ff.dp_q) || (i_dm != st_ff.dm_q) ||
                (i_id_pin != st_ff.id_q) || (i_sess_vld != st_ff.sv_q);
    ev[BIT_IDENT] = st_ff.primed && (i_id_pin != st_ff.id_q);
    ev[BIT_TICK] = tif.tick;
    ev[BIT_LINE] = tif.settle_evt;
    ev[BIT_ACTV] = st_ff.primed && i_suspend && pin_moved;
    ev[BIT_SESSION_VALID_INDICATOR] = st_ff.primed && i_sess_end && !st_ff.se_q;
    ev[BIT_SESSION_END_INDICATOR] = st_ff.primed && (i_sess_end != st_ff.se_q);
    ev[BIT_A_DEVICE_VBUS_VALID_INDICATOR] = st_ff.primed && (i_sess_vld != st_ff.sv_q);
    ev = ev & EVT_IMPL;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.primed = 1'b1;
    nxt_st.id_q = i_id_pin;
    nxt_st.dp_q = i_dp;
    nxt_st.dm_q = i_dm;
    nxt_st.sv_q = i_sess_vld;
    nxt_st.se_q = i_sess_end;
    wr_clr = FLAGS_RST;
    if (i_wr && reg_hit(i_addr, OFF_EVENT_FLAGS)) begin
      wr_clr = i_wdata[FLAG_W-1:0] & EVT_IMPL;
    end
    // set wins over clear
    nxt_st.evt = (st_ff.evt & ~wr_clr) | ev;
    if (i_rd && reg_hit(i_addr, OFF_IRQ_STATUS)) begin
      nxt_st.irq_st = ev; // read clears, fresh events kept
    end else begin
      nxt_st.irq_st = st_ff.irq_st | ev;
    end
    if (i_wr && reg_hit(i_addr, OFF_IRQ_MASK)) begin
      nxt_st.irq_mask = i_wdata[FLAG_W-1:0] & EVT_IMPL;
    end
    nxt_st.live = FLAGS_RST;
    nxt_st.live[BIT_IDENT] = i_id_pin;
    nxt_st.live[BIT_LINE] = tif.line_stable;
    nxt_st.live[BIT_SESSION_VALID_INDICATOR] = i_sess_vld;
    nxt_st.live[BIT_SESSION_END_INDICATOR] = !i_a_device && !i_sess_vld;
    nxt_st.live[BIT_A_DEVICE_VBUS_VALID_INDICATOR] = i_a_device && i_sess_vld;
    // read data stands for one cycle only, zero otherwise
    nxt_st.rdata = RDATA_RST;
    if (i_rd) begin
      if (reg_hit(i_addr, OFF_EVENT_FLAGS)) begin
        nxt_st.rdata[FLAG_W-1:0] = st_ff.evt;
      end else if (reg_hit(i_addr, OFF_LIVE_STATUS)) begin
        nxt_st.rdata[FLAG_W-1:0] = st_ff.live & STAT_IMPL;
      end else if (reg_hit(i_addr, OFF_IRQ_STATUS)) begin
        nxt_st.rdata[FLAG_W-1:0] = st_ff.irq_st;
      end else if (reg_hit(i_addr, OFF_IRQ_MASK)) begin
        nxt_st.rdata[FLAG_W-1:0] = st_ff.irq_mask;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_irq = |(st_ff.irq_st & st_ff.irq_mask);

endmodule : usbo_otg_event_flags

/* File: usbo_pkg.sv */
package usbo_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / US_PER_S) * TICK_TIME_US;
  localparam int unsigned CNT_W = 16;

  // register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_EVENT_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LIVE_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;

  // bit positions, shared by event, status, irq and mask registers
  localparam int unsigned BIT_IDENT = 7;
  localparam int unsigned BIT_TICK = 6;
  localparam int unsigned BIT_LINE = 5;
  localparam int unsigned BIT_ACTV = 4;
  localparam int unsigned BIT_SESSION_VALID_INDICATOR = 3;
  localparam int unsigned BIT_SESSION_END_INDICATOR = 2;
  localparam int unsigned BIT_A_DEVICE_VBUS_VALID_INDICATOR = 0;

  localparam int unsigned FLAG_W = 8;
  localparam logic [FLAG_W-1:0] EVT_IMPL = 8'hFD;
  localparam logic [FLAG_W-1:0] STAT_IMPL = 8'hAD;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

endpackage : usbo_pkg

/* File: usbo_tmr_if.sv */
`timescale 1ns/1ps
interface usbo_tmr_if;
  logic single_ended_zero_line;
  logic j_state_line;
  logic tick;
  logic line_stable;
  logic settle_evt;

  modport timer (
    input single_ended_zero_line,
    input j_state_line,
    output tick,
    output line_stable,
    output settle_evt
  );

  modport core (
    output single_ended_zero_line,
    output j_state_line,
    input tick,
    input line_stable,
    input settle_evt
  );
endinterface : usbo_tmr_if

/* File: usbo_line_timer.sv */
`timescale 1ns/1ps
module usbo_line_timer
  import usbo_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // line and timer signals
  usbo_tmr_if.timer tif
);

  typedef struct packed {
    logic [CNT_W-1:0] tick_cnt;
    logic tick;
    logic [1:0] line_prev;
    logic [CNT_W-1:0] stab_cnt;
    logic stable;
    logic [1:0] settled;
    logic settle_evt;
  } usbo_tmr_s;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(MS_CYCLES - 1);

  usbo_tmr_s st_ff;
  usbo_tmr_s nxt_st;
  logic [1:0] line;

  assign line = {tif.single_ended_zero_line, tif.j_state_line};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.settle_evt = 1'b0;
    // free running millisecond tick
    if (st_ff.tick_cnt == LAST) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + CNT_W'(1);
      nxt_st.tick = 1'b0;
    end
    nxt_st.line_prev = line;
    // any line change restarts the stability window
    if (line != st_ff.line_prev) begin
      nxt_st.stab_cnt = '0;
      nxt_st.stable = 1'b0;
    end else if (st_ff.stab_cnt != LAST) begin
      nxt_st.stab_cnt = st_ff.stab_cnt + CNT_W'(1);
    end else if (!st_ff.stable) begin
      nxt_st.stable = 1'b1;
      // only a new settled state raises the flag
      if (line != st_ff.settled) begin
        nxt_st.settle_evt = 1'b1;
        nxt_st.settled = line;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tif.tick = st_ff.tick;
  assign tif.line_stable = st_ff.stable;
  assign tif.settle_evt = st_ff.settle_evt;

endmodule : usbo_line_timer

/* File: usbo_cable_model.sv */
`timescale 1ns/1ps
module usbo_cable_model (
  // commands
  input wire logic i_plug_a,
  input wire logic [1:0] i_vbus,
  input wire logic [1:0] i_line,
  // cable pins
  output logic o_id,
  output logic o_dp,
  output logic o_dm,
  output logic o_se0,
  output logic o_j,
  output logic o_sess_vld,
  output logic o_sess_end
);
  // id pulled high unless an a plug grounds it
  assign o_id = !i_plug_a;
  // vbus level 0 below end, 1 between, 2 above valid
  assign o_sess_vld = i_vbus == 2'h2;
  assign o_sess_end = i_vbus == 2'h0;
  // line code 0 se0, 1 j, 2 k
  assign o_dp = i_line == 2'h1;
  assign o_dm = i_line == 2'h2;
  assign o_se0 = i_line == 2'h0;
  assign o_j = i_line == 2'h1;
endmodule : usbo_cable_model

/* File: usbo_chk.sv */
`timescale 1ns/1ps
module usbo_chk
  import usbo_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
  // all inputs
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic i_id_pin,
  input wire logic i_dp,
  input wire logic i_sess_vld,
  input wire logic i_sess_end,
  input wire logic i_a_device,
  input wire logic i_suspend,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // shadow of the mask, irq checks only meaningful where unmasked
  logic [7:0] msk_ff;
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) msk_ff <= 8'h00;
    else if (i_wr && i_addr == OFF_IRQ_MASK) msk_ff <= i_wdata[7:0];
  AST_EVT_RSVD: assert property ($past(i_rd) &&
    $past(i_addr) == OFF_EVENT_FLAGS |-> o_rdata[31:8] == 24'h0 &&
    !o_rdata[1]) else $error("event reserved bits set");
  AST_STAT_RSVD: assert property ($past(i_rd) &&
    $past(i_addr) == OFF_LIVE_STATUS |->
    (o_rdata & ~{24'h0, STAT_IMPL}) == 32'h0) else $error("status rsvd");
  // stable inputs only, so either lag of the live copy passes
  AST_ID_LIVE: assert property ($past(i_rd) &&
    $past(i_addr) == OFF_LIVE_STATUS &&
    $past(i_id_pin, 2) == $past(i_id_pin, 3) |->
    o_rdata[BIT_IDENT] == $past(i_id_pin, 2)) else $error("id live");
  AST_SESS_LIVE: assert property ($past(i_rd) &&
    $past(i_addr) == OFF_LIVE_STATUS &&
    $past({i_sess_vld, i_a_device}, 2) == $past({i_sess_vld, i_a_device}, 3)
    |-> {o_rdata[3:2], o_rdata[0]} == {$past(i_sess_vld, 2),
    !$past(i_a_device, 2) && !$past(i_sess_vld, 2),
    $past(i_a_device, 2) && $past(i_sess_vld, 2)}) else $error("sess live");
  AST_ID_IRQ: assert property ($changed(i_id_pin) &&
    msk_ff[BIT_IDENT] |-> ##[1:2] o_irq) else $error("id irq");
  AST_SEND_IRQ: assert property ($rose(i_sess_end) &&
    msk_ff[BIT_SESSION_VALID_INDICATOR] |-> ##[1:2] o_irq) else $error("end irq");
  AST_SECH_IRQ: assert property ($changed(i_sess_end) &&
    msk_ff[BIT_SESSION_END_INDICATOR] |-> ##[1:2] o_irq) else $error("end chg irq");
  AST_VB_IRQ: assert property ($changed(i_sess_vld) &&
    msk_ff[BIT_A_DEVICE_VBUS_VALID_INDICATOR] |-> ##[1:2] o_irq) else $error("vbus irq");
  AST_ACT_IRQ: assert property (i_suspend && $changed(i_dp) &&
    msk_ff[BIT_ACTV] |-> ##[1:2] o_irq) else $error("activity irq");
endmodule : usbo_chk
bind usbo_otg_event_flags usbo_chk #(.MS_CYCLES(MS_CYCLES)) i_usbo_chk (.*);

/* File: usbo_otg_event_flags_tb.sv */
`timescale 1ns/1ps
module usbo_otg_event_flags_tb;
  import usbo_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, i_plug_a, i_a_device, i_suspend, o_irq;
  logic i_id_pin, i_dp, i_dm, i_single_ended_zero_line, i_j_state_line;
  logic i_sess_vld, i_sess_end;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata, rd_d;
  logic [1:0] i_vbus, i_line;
  int err_count, num_checks, cyc;
  // {plug_a, vbus level, a_device, live status bits 7,3,2,0}
  logic [11:0] rows [4] = '{12'h488, 12'hD09, 12'h084, 12'hB00};
  // short millisecond keeps the run brief
  usbo_otg_event_flags #(.MS_CYCLES(20)) i_usbo_otg_event_flags (.*);
  usbo_cable_model i_usbo_cable_model (.i_plug_a(i_plug_a),
    .i_vbus(i_vbus), .i_line(i_line), .o_id(i_id_pin), .o_dp(i_dp),
    .o_dm(i_dm), .o_se0(i_single_ended_zero_line), .o_j(i_j_state_line),
    .o_sess_vld(i_sess_vld), .o_sess_end(i_sess_end));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_d = o_rdata;
  endtask : rd
  initial begin
    {i_rst_n, i_wr, i_rd, i_plug_a, i_a_device, i_suspend} = '0;
    i_addr = '0;
    i_wdata = '0;
    i_vbus = '0;
    i_line = 2'h1;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(OFF_EVENT_FLAGS);
    chk("flags rst", 32'h0, rd_d);
    rd(OFF_IRQ_MASK);
    chk("mask rst", 32'h0, rd_d);
    wr(OFF_IRQ_MASK, 32'hFD);
    for (int k = 0; k < 4; k++) begin
      {i_plug_a, i_vbus, i_a_device} <= rows[k][11:8];
      repeat (30) @(posedge i_clk);
      rd(OFF_LIVE_STATUS);
      chk("live", {24'h0, rows[k][7:0]}, rd_d & 32'h8D);
    end
    rd(OFF_EVENT_FLAGS);
    chk("flags", 32'hED, rd_d);
    wr(OFF_EVENT_FLAGS, 32'h0);
    rd(OFF_EVENT_FLAGS);
    chk("write zero", 32'hED, rd_d);
    wr(OFF_EVENT_FLAGS, 32'hFFFF_FFBF);
    rd(OFF_EVENT_FLAGS);
    chk("w1c", 32'h0, rd_d & 32'hFFFF_FFBF);
    i_suspend <= 1'b1;
    i_line <= 2'h2;
    repeat (3) @(posedge i_clk);
    rd(OFF_LIVE_STATUS);
    chk("line unstable", 32'h0, rd_d & 32'h20);
    rd(OFF_EVENT_FLAGS);
    chk("activity", 32'h10, rd_d & 32'h30);
    repeat (30) @(posedge i_clk);
    rd(OFF_LIVE_STATUS);
    chk("line stable", 32'h20, rd_d & 32'h20);
    rd(OFF_EVENT_FLAGS);
    chk("line flag", 32'h20, rd_d & 32'h20);
    wr(OFF_IRQ_MASK, 32'h01);
    rd(OFF_IRQ_STATUS);
    chk("irq clear", 32'h0, {31'h0, o_irq});
    i_vbus <= 2'h2;
    repeat (3) @(posedge i_clk);
    chk("irq set", 32'h1, {31'h0, o_irq});
    wr(OFF_IRQ_MASK, 32'h0);
    #1 chk("irq masked", 32'h0, {31'h0, o_irq});
    rd(8'h10);
    chk("unmapped", 32'h0, rd_d);
    // vbus edge above set irq bit 0, no read since
    rd(OFF_IRQ_STATUS);
    chk("irq status", 32'h1, rd_d & 32'h1);
    // reset in mid run with flags standing and pins away from reset values
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(OFF_EVENT_FLAGS);
    chk("flags rerst", 32'h0, rd_d);
    rd(OFF_IRQ_MASK);
    chk("mask rerst", 32'h0, rd_d);
    end_sim();
  end
endmodule : usbo_otg_event_flags_tb
